// >>> hw/system_clock_select_control.sv
`timescale 1ns/1ps
module system_clock_select_control (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    // oscillator status from analog side
    input wire logic main_osc_stable,
    // clock control outputs
    output clock_select_pkg::clock_ctrl_t clock_ctrl,
    output logic [3:0] cpu_clock_divide
);

    // register contents
    // protect register: only bit0 has an effect
    logic [7:0] write_protect;
    logic [7:0] control_zero;
    logic [7:0] control_one;
    logic [7:0] control_three;
    logic [7:0] stop_detect;
    // tuning registers: stored and read back, no decode here
    logic [7:0] fast_osc [4];

    // next values
    // register values from the write decode into storage; outputs from the control decode and read mux into output registers
    logic [7:0] next_write_protect;
    logic [7:0] next_control_zero;
    logic [7:0] next_control_one;
    logic [7:0] next_control_three;
    logic [7:0] next_stop_detect;
    logic [7:0] next_fast_osc [4];
    logic [7:0] next_reg_rdata;
    clock_select_pkg::clock_ctrl_t next_clock_ctrl;
    logic [3:0] next_cpu_clock_divide;

    // unlock state of the protected group
    // taken straight from the stored protect bit
    logic unlocked;

    // protection bit gates the whole clock group
    assign unlocked = write_protect[clock_select_pkg::pos_clock_regs_write_enable];

    // register write decode
    always_comb begin
        next_write_protect = write_protect;
        next_control_zero = control_zero;
        next_control_one = control_one;
        next_control_three = control_three;
        next_stop_detect = stop_detect;
        for (int i = 0; i < 4; i++) begin
            next_fast_osc[i] = fast_osc[i];
        end
        if (reg_write) begin
            // protect register itself is always writable
            if (reg_addr == clock_select_pkg::off_clock_write_protect) begin
                next_write_protect = reg_wdata;
            end
            // locked writes are dropped silently
            if (unlocked) begin
                case (reg_addr)
                    // main crystal stop, source select, divider enable
                    clock_select_pkg::off_clock_control_zero: begin
                        next_control_zero = reg_wdata;
                    end

                    // low-speed stop, pin switch, divider field
                    clock_select_pkg::off_clock_control_one: begin
                        next_control_one = reg_wdata;
                    end

                    // third control register, stored only
                    clock_select_pkg::off_clock_control_three: begin
                        next_control_three = reg_wdata;
                    end

                    // system clock source select
                    clock_select_pkg::off_osc_stop_detect: begin
                        next_stop_detect = reg_wdata;
                    end

                    // tuning register zero
                    clock_select_pkg::off_fast_osc_ctrl_zero: begin
                        next_fast_osc[0] = reg_wdata;
                    end

                    // tuning register one
                    clock_select_pkg::off_fast_osc_ctrl_one: begin
                        next_fast_osc[1] = reg_wdata;
                    end

                    // tuning register two
                    clock_select_pkg::off_fast_osc_ctrl_two: begin
                        next_fast_osc[2] = reg_wdata;
                    end

                    // tuning register three
                    clock_select_pkg::off_fast_osc_ctrl_three: begin
                        next_fast_osc[3] = reg_wdata;
                    end

                    // protect, status and unmapped offsets
                    default: begin
                    end
                endcase
            end
        end
    end

    // register storage
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            // locked after reset
            write_protect <= clock_select_pkg::rst_clock_write_protect;

            // crystal stopped, divider field off
            control_zero <= clock_select_pkg::rst_clock_control_zero;

            // low-speed stopped, pins as ports
            control_one <= clock_select_pkg::rst_clock_control_one;
            control_three <= clock_select_pkg::rst_clock_control_three;

            // system clock not from crystal
            stop_detect <= clock_select_pkg::rst_osc_stop_detect;

            // tuning registers cleared
            for (int i = 0; i < 4; i++) begin
                fast_osc[i] <= clock_select_pkg::rst_fast_osc_ctrl;
            end
        end else begin
            // take the decoded next values
            write_protect <= next_write_protect;
            control_zero <= next_control_zero;
            control_one <= next_control_one;
            control_three <= next_control_three;
            stop_detect <= next_stop_detect;
            for (int i = 0; i < 4; i++) begin
                fast_osc[i] <= next_fast_osc[i];
            end
        end
    end

    // control decode from register fields
    always_comb begin
        // stop bit clear keeps the low-speed oscillator on
        next_clock_ctrl.low_speed_osc_run =
            ~control_one[clock_select_pkg::pos_low_speed_osc_stop];

        // pin switch set hands both pins to the crystal
        next_clock_ctrl.crystal_pins_enable =
            control_one[clock_select_pkg::pos_osc_pin_function_select];

        // stop bit clear keeps the main crystal running
        next_clock_ctrl.main_osc_run =
            ~control_zero[clock_select_pkg::pos_main_osc_stop];

        // select bit clear picks the crystal over the sub-clock
        next_clock_ctrl.main_clock_is_crystal =
            ~control_zero[clock_select_pkg::pos_main_sub_clock_select];

        // source bit clear makes the crystal the system clock
        next_clock_ctrl.system_clock_is_crystal =
            ~stop_detect[clock_select_pkg::pos_system_clock_source_select];

        // two-bit divider field, high bit first
        next_clock_ctrl.cpu_divider = {control_one[clock_select_pkg::pos_cpu_divider_high],
                                       control_one[clock_select_pkg::pos_cpu_divider_low]};

        // enable bit clear lets the field set the ratio
        next_clock_ctrl.cpu_divider_from_field =
            ~control_zero[clock_select_pkg::pos_cpu_divider_field_enable];

        // log2 of division ratio; field off means divide by eight
        if (next_clock_ctrl.cpu_divider_from_field) begin
            if (next_clock_ctrl.cpu_divider == clock_select_pkg::div_none) begin
                next_cpu_clock_divide = 4'h0;
            end else begin
                next_cpu_clock_divide = {2'h0, next_clock_ctrl.cpu_divider};
            end
        end else begin
            next_cpu_clock_divide = 4'h3;
        end
    end

    // read data mux, answered one cycle later
    always_comb begin
        // idle bus reads back zero
        next_reg_rdata = 8'h00;
        if (reg_read) begin
            case (reg_addr)
                // protect register
                clock_select_pkg::off_clock_write_protect: begin
                    next_reg_rdata = write_protect;
                end

                // control register zero
                clock_select_pkg::off_clock_control_zero: begin
                    next_reg_rdata = control_zero;
                end

                // control register one
                clock_select_pkg::off_clock_control_one: begin
                    next_reg_rdata = control_one;
                end

                // control register three
                clock_select_pkg::off_clock_control_three: begin
                    next_reg_rdata = control_three;
                end

                // system clock source register
                clock_select_pkg::off_osc_stop_detect: begin
                    next_reg_rdata = stop_detect;
                end

                // tuning register zero
                clock_select_pkg::off_fast_osc_ctrl_zero: begin
                    next_reg_rdata = fast_osc[0];
                end

                // tuning register one
                clock_select_pkg::off_fast_osc_ctrl_one: begin
                    next_reg_rdata = fast_osc[1];
                end

                // tuning register two
                clock_select_pkg::off_fast_osc_ctrl_two: begin
                    next_reg_rdata = fast_osc[2];
                end

                // tuning register three
                clock_select_pkg::off_fast_osc_ctrl_three: begin
                    next_reg_rdata = fast_osc[3];
                end

                // live status: stable flag, unlock and selected source
                clock_select_pkg::off_clock_status: begin
                    next_reg_rdata = {5'h00, clock_ctrl.system_clock_is_crystal,
                                      unlocked, main_osc_stable};
                end
                default: next_reg_rdata = 8'h00;
            endcase
        end
    end

    // output registers
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            // quiet outputs while in reset
            reg_rdata <= 8'h00;
            clock_ctrl <= '0;
            cpu_clock_divide <= 4'h0;
        end else begin
            // read data stands for one cycle only
            reg_rdata <= next_reg_rdata;

            // control outputs follow registers one cycle late
            clock_ctrl <= next_clock_ctrl;
            cpu_clock_divide <= next_cpu_clock_divide;
        end
    end

endmodule

// >>> include/clock_select_pkg.sv
package clock_select_pkg;

    // register offsets on the plain register port
    localparam logic [3:0] off_clock_write_protect = 4'h0;
    localparam logic [3:0] off_clock_control_zero = 4'h1;
    localparam logic [3:0] off_clock_control_one = 4'h2;
    localparam logic [3:0] off_clock_control_three = 4'h3;
    localparam logic [3:0] off_osc_stop_detect = 4'h4;
    localparam logic [3:0] off_fast_osc_ctrl_zero = 4'h5;
    localparam logic [3:0] off_fast_osc_ctrl_one = 4'h6;
    localparam logic [3:0] off_fast_osc_ctrl_two = 4'h7;
    localparam logic [3:0] off_fast_osc_ctrl_three = 4'h8;
    localparam logic [3:0] off_clock_status = 4'h9;

    // field positions
    localparam int pos_clock_regs_write_enable = 0;
    localparam int pos_low_speed_osc_stop = 4;
    localparam int pos_osc_pin_function_select = 3;
    localparam int pos_cpu_divider_low = 6;
    localparam int pos_cpu_divider_high = 7;
    localparam int pos_main_osc_stop = 5;
    localparam int pos_cpu_divider_field_enable = 6;
    localparam int pos_main_sub_clock_select = 7;
    localparam int pos_system_clock_source_select = 2;

    // reset values: everything stopped, pins as ports, divider field off
    localparam logic [7:0] rst_clock_write_protect = 8'h00;
    localparam logic [7:0] rst_clock_control_zero = 8'h60;
    localparam logic [7:0] rst_clock_control_one = 8'hd0;
    localparam logic [7:0] rst_clock_control_three = 8'h00;
    localparam logic [7:0] rst_osc_stop_detect = 8'h04;
    localparam logic [7:0] rst_fast_osc_ctrl = 8'h00;

    // cpu divider field codes
    localparam logic [1:0] div_none = 2'h0;

    // control outputs carried together
    typedef struct packed {
        logic low_speed_osc_run;
        logic crystal_pins_enable;
        logic main_osc_run;
        logic main_clock_is_crystal;
        logic system_clock_is_crystal;
        logic [1:0] cpu_divider;
        logic cpu_divider_from_field;
    } clock_ctrl_t;

endpackage

// >>> verif/system_clock_select_control_assertions.sv
`timescale 1ns/1ps
module clock_select_checker (
    // clock, reset and register port
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    // control outputs
    input wire clock_select_pkg::clock_ctrl_t clock_ctrl,
    input wire logic [3:0] cpu_clock_divide
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic unl; // mirror of the write-enable bit
    logic [7:0] wd1, wd2; // write data delayed to output time
    // delay write data, track unlock state
    always_ff @(posedge clk_sys) begin
        wd1 <= reg_wdata;
        wd2 <= wd1;
        if (rst) unl <= 1'b0;
        else if (reg_write && reg_addr == clock_select_pkg::off_clock_write_protect) unl <= reg_wdata[0];
    end
    // accepted and refused writes
    sequence s_cc0; reg_write && unl && reg_addr == clock_select_pkg::off_clock_control_zero; endsequence
    sequence s_cc1; reg_write && unl && reg_addr == clock_select_pkg::off_clock_control_one; endsequence
    sequence s_osd; reg_write && unl && reg_addr == clock_select_pkg::off_osc_stop_detect; endsequence
    sequence s_lock; reg_write && !unl && reg_addr inside {[4'h1:4'h8]}; endsequence
    property p_ls; s_cc1 |-> ##2 clock_ctrl.low_speed_osc_run == !wd2[4]; endproperty
    a_ls: assert property (p_ls) else $error("low speed osc run wrong");
    property p_pin; s_cc1 |-> ##2 clock_ctrl.crystal_pins_enable == wd2[3]; endproperty
    a_pin: assert property (p_pin) else $error("crystal pin select wrong");
    property p_div; s_cc1 |-> ##2 clock_ctrl.cpu_divider == wd2[7:6]; endproperty
    a_div: assert property (p_div) else $error("divider field wrong");
    property p_mo; s_cc0 |-> ##2 clock_ctrl.main_osc_run == !wd2[5]; endproperty
    a_mo: assert property (p_mo) else $error("main osc run wrong");
    property p_mc; s_cc0 |-> ##2 clock_ctrl.main_clock_is_crystal == !wd2[7]; endproperty
    a_mc: assert property (p_mc) else $error("main clock select wrong");
    property p_sys; s_osd |-> ##2 clock_ctrl.system_clock_is_crystal == !wd2[2]; endproperty
    a_sys: assert property (p_sys) else $error("system clock select wrong");
    property p_fld; clock_ctrl.cpu_divider_from_field |-> cpu_clock_divide == {2'h0, clock_ctrl.cpu_divider}; endproperty
    a_fld: assert property (p_fld) else $error("divide ratio not from field");
    property p_lock; s_lock |-> ##2 $stable(clock_ctrl); endproperty
    a_lock: assert property (p_lock) else $error("locked write changed outputs");
endmodule
bind system_clock_select_control clock_select_checker u_chk (
    .clk_sys, .rst, .reg_addr, .reg_wdata, .reg_write, .clock_ctrl, .cpu_clock_divide);

// >>> verif/tb_system_clock_select_control.sv
`timescale 1ns/1ps
module tb_system_clock_select_control;
    localparam logic [3:0] a_prot = clock_select_pkg::off_clock_write_protect;
    localparam logic [3:0] a_cc0 = clock_select_pkg::off_clock_control_zero;
    localparam logic [3:0] a_cc1 = clock_select_pkg::off_clock_control_one;
    localparam logic [3:0] a_osd = clock_select_pkg::off_osc_stop_detect;
    // stimulus and observed outputs
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic main_osc_stable = 1'b0;
    logic [7:0] reg_rdata;
    clock_select_pkg::clock_ctrl_t clock_ctrl;
    logic [3:0] cpu_clock_divide;
    // expected register contents
    logic unl = 1'b0;
    logic [7:0] m0 = clock_select_pkg::rst_clock_control_zero;
    logic [7:0] m1 = clock_select_pkg::rst_clock_control_one;
    logic [7:0] mo = clock_select_pkg::rst_osc_stop_detect;
    int num_errors = 0;
    int total_checks = 0;
    int cycles = 0;
    always #50 clk_sys = ~clk_sys;
    system_clock_select_control dut (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
        .main_osc_stable, .clock_ctrl, .cpu_clock_divide);
    // compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one-cycle write strobe
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk_sys);
        reg_write <= 1'b0;
    endtask
    // read strobe, data in the following cycle
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        #1;
        check(reg_rdata, exp);
    endtask
    // write, update expectation, then compare control outputs
    task automatic wc(input logic [3:0] a, input logic [7:0] d);
        wr(a, d);
        if (a == a_prot) unl = d[0];
        else if (unl && a == a_cc0) m0 = d;
        else if (unl && a == a_cc1) m1 = d;
        else if (unl && a == a_osd) mo = d;
        @(posedge clk_sys);
        #1;
        check(clock_ctrl, {~m1[4], m1[3], ~m0[5], ~m0[7], ~mo[2], m1[7:6], ~m0[6]});
        check({4'h0, cpu_clock_divide}, m0[6] ? 8'h03 : {6'h00, m1[7:6]});
    endtask
    // verdict and end of run
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // hang guard
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 2000) begin
            num_errors++;
            print_verdict();
        end
    end
    initial begin
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        wc(4'ha, 8'hff);
        rd(a_prot, 8'h00);
        rd(a_cc0, m0);
        rd(a_osd, mo);
        wc(a_cc1, 8'h00);
        rd(a_cc1, m1);
        $display("test reset_and_lock done");
        wc(a_prot, 8'h01);
        wc(a_cc1, 8'hc0);
        wc(a_cc1, 8'hc8);
        wc(a_cc0, 8'h40);
        main_osc_stable <= 1'b1;
        rd(4'h9, 8'h03);
        wc(a_cc0, 8'hc0);
        wc(a_cc0, 8'h40);
        wc(a_osd, 8'h00);
        for (int i = 3; i >= 0; i--) wc(a_cc1, {i[1:0], 6'h08});
        wc(a_cc0, 8'h00);
        for (int i = 3; i >= 0; i--) wc(a_cc1, {i[1:0], 6'h08});
        $display("test clock_bring_up done");
        wc(a_prot, 8'h00);
        wc(a_cc0, 8'hff);
        rd(a_cc0, 8'h00);
        rd(4'ha, 8'h00);
        rd(4'h9, 8'h05);
        $display("test relock done");
        print_verdict();
    end
endmodule
